// File: src/sdc_buffer_cache.sv
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sdc_consts.svh"
// Function
// R1 - 16 MB buffer, 13000 KB split into segments
// R2 - Track held block range per segment
// R3 - Read caching on: try buffer before medium
// R4 - Read caching off: bypass lookup, pass through
// R5 - Full hit: send blocks without medium access
// R6 - Miss: fill segment from medium, then forward
// R7 - Circular whole-block segments, allocated by workload
// R8 - Segment size reads 0xFFFF, writes ignored
// R9 - Param_check_a checking rejects segment size writes
// R10 - Read caching on: keep written data cached
// R11 - Segmentation independent of read cache flag
// R12 - Write invalidates overlapping segments before caching
// R13 - Wrapping never overwrites uncommitted data
// R14 - Write caching: good status once cached
// R15 - Failed later commit raises deferred error
// R16 - Sync completes after all writes committed
// R17 - Prefetch following blocks even without caching
// R18 - Prefetch hit counted apart from cache hit
// R19 - Read ahead disable flag zero enables prefetch
// R20 - Max prefetch and ceiling fields ignored
// R21 - Prefetch only when a hit is predicted
// R22 - Host transfers paced by buffer-full ratio
// R23 - Host sets caching and prefetch flags separately
// R24 - Host treats data durable after sync
module sdc_buffer_cache #(
	parameter int NSEG       = `SDC_NSEG,
	parameter int SEG_BLOCKS = `SDC_CACHE_BLOCKS / `SDC_NSEG,
	parameter int LBA_W      = 32
) (
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output wire logic                 s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output wire logic                 s_axi_wready,
	output wire logic [1:0]           s_axi_bresp,
	output wire logic                 s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output wire logic                 s_axi_arready,
	output wire logic [31:0]          s_axi_rdata,
	output wire logic [1:0]           s_axi_rresp,
	output wire logic                 s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 cmd_valid,
	output wire logic                 cmd_ready,
	input  wire sdc_pkg::sdc_op_type  cmd_op,
	input  wire logic [LBA_W-1:0]     cmd_lba,
	input  wire logic [15:0]          cmd_count,
	output wire logic                 cmd_done,
	output wire logic                 cmd_good,
	output wire sdc_pkg::sdc_hit_type cmd_hit,
	output wire logic                 rd_blk_valid,
	input  wire logic                 rd_blk_ready,
	output wire logic [LBA_W-1:0]     rd_blk_lba,
	input  wire logic                 wr_blk_valid,
	output wire logic                 wr_blk_ready,
	output wire logic                 med_valid,
	input  wire logic                 med_ready,
	output wire logic                 med_write,
	output wire logic [LBA_W-1:0]     med_lba,
	output wire logic [15:0]          med_count,
	input  wire logic                 med_blk,
	input  wire logic                 med_done,
	input  wire logic                 med_err,
	output wire logic                 deferred_error
);
	import sdc_pkg::*;

	localparam int          SW    = (NSEG > 1) ? $clog2(NSEG) : 1;
	localparam logic [15:0] SEG_B = 16'(SEG_BLOCKS);  // Blocks per segment, see R1

	// One directory entry per segment
	typedef struct packed {
		logic             valid;   // Entry holds usable data
		logic             dirty;   // Data not yet on medium
		logic [LBA_W-1:0] start;   // First block held
		logic [15:0]      dem;     // Blocks asked for by host
		logic [15:0]      total;   // Blocks held, prefetch included
	} sdc_seg_type;

	// Whole controller state
	typedef struct packed {
		sdc_seg_type [NSEG-1:0] seg;      // Segment directory
		sdc_fsm_type            fsm;      // Controller state
		sdc_fsm_type            ret;      // State after a flush
		logic [SW-1:0]          cur;      // Segment in use
		logic [SW-1:0]          rr;       // Next eviction candidate
		sdc_op_type             op;       // Current command
		logic [LBA_W-1:0]       lba;      // Command start block
		logic [15:0]            count;    // Command length
		logic [15:0]            sent;     // Blocks given to host
		logic [15:0]            avail;    // Blocks in buffer
		logic [15:0]            rcvd;     // Write blocks taken
		logic [15:0]            commit;   // Write blocks on medium
		logic                   started;  // Host burst begun
		logic                   mdone;    // Medium finished
		logic                   wthru;    // Streaming write
		logic                   dfl;      // Flush errors are deferred
		logic                   good;     // Command status
		sdc_hit_type            hit;      // Read outcome
		logic [1:0]             pred;     // Prefetch predictor
		logic [LBA_W-1:0]       last_end; // End of previous read
		logic [LBA_W-1:0]       rlba;     // Block offered to host
		logic [LBA_W-1:0]       mlba;     // Medium request start
		logic [15:0]            mcnt;     // Medium request length
		logic                   mwr;      // Medium request is write
		logic                   done;     // Completion pulse
		logic                   defer;    // Deferred error pulse
		logic [3:0]             ctrl;     // Cache control flags
		logic [7:0]             ratio;    // Buffer-full ratio
		logic                   def_st;   // Sticky deferred error
		logic [15:0]            n_chit;   // Cache hit count
		logic [15:0]            n_phit;   // Prefetch hit count
		logic [15:0]            n_miss;   // Miss count
		logic                   aw_got;   // Write address held
		logic [7:0]             awaddr;   // Held write address
		logic                   w_got;    // Write data held
		logic [31:0]            wdata;    // Held write data
		logic [3:0]             wstrb;    // Held byte strobes
		logic                   bvalid;   // Write response pending
		logic [1:0]             bresp;    // Write response code
		logic                   rvalid;   // Read data pending
		logic [31:0]            rdata;    // Read data
		logic [1:0]             rresp;    // Read response code
	} sdc_state_type;

	sdc_state_type    q;        // Registered state
	sdc_state_type    n;        // Next state
	logic [NSEG-1:0]  hit_v;    // Request fully held
	logic [NSEG-1:0]  pf_v;     // Request reaches prefetched part
	logic [NSEG-1:0]  ovl_v;    // Request overlaps entry
	logic [NSEG-1:0]  dirty_v;  // Entry awaits commit
	logic [NSEG-1:0]  free_v;   // Entry unused
	logic [LBA_W-1:0] req_end;  // One past last requested block
	logic [23:0]      thr_prod; // Ratio times segment size
	logic [15:0]      thr;      // Blocks needed before a burst
	logic             pf_on;    // Prefetch currently wanted

	// Widen a block count to address width
	function automatic logic [LBA_W-1:0] ext(input logic [15:0] c);
		return LBA_W'(c);
	endfunction

	// Lowest set bit of a segment vector
	function automatic logic [SW-1:0] first_idx(input logic [NSEG-1:0] v);
		logic [SW-1:0] r;
		r = '0;
		for (int k = NSEG - 1; k >= 0; k--) begin
			if (v[k]) begin
				r = SW'(k);
			end
		end
		return r;
	endfunction

	assign req_end  = q.lba + ext(q.count);
	assign thr_prod = q.ratio * SEG_B;
	assign thr      = thr_prod[23:8];                              // see R22
	assign pf_on    = !q.ctrl[`SDC_CTRL_PFO] && q.pred[1];          // see R19 R21

	// Per-segment address compare
	for (genvar i = 0; i < NSEG; i++) begin : g_seg
		logic [LBA_W-1:0] s_end;  // One past last held block
		assign s_end      = q.seg[i].start + ext(q.seg[i].total);
		assign hit_v[i]   = q.seg[i].valid && q.lba >= q.seg[i].start && req_end <= s_end;  // see R2
		assign pf_v[i]    = req_end > q.seg[i].start + ext(q.seg[i].dem);
		assign ovl_v[i]   = q.seg[i].valid && q.lba < s_end && req_end > q.seg[i].start;
		assign dirty_v[i] = q.seg[i].valid && q.seg[i].dirty;
		assign free_v[i]  = !q.seg[i].valid;
	end

	// Handshake outputs
	assign s_axi_awready = !q.aw_got && !q.bvalid;
	assign s_axi_wready  = !q.w_got && !q.bvalid;
	assign s_axi_arready = !q.rvalid;
	assign cmd_ready     = (q.fsm == SDC_IDLE);
	assign med_valid     = (q.fsm == SDC_RD_REQ) || (q.fsm == SDC_WR_REQ) || (q.fsm == SDC_FL_REQ);
	// Burst starts at ratio or full fill
	assign rd_blk_valid  = (q.fsm == SDC_RD_XFER) && q.good && q.sent < q.count && q.avail > q.sent
		&& (q.started || q.mdone || q.avail - q.sent >= thr || q.avail >= q.count);  // see R22
	// Streaming writes stall the host rather than lap uncommitted data
	assign wr_blk_ready  = (q.fsm == SDC_WR_IN) && q.rcvd < q.count
		&& (!q.wthru || q.rcvd - q.commit < SEG_B);  // see R13

	// Registered outputs
	assign s_axi_bresp    = q.bresp;
	assign s_axi_bvalid   = q.bvalid;
	assign s_axi_rdata    = q.rdata;
	assign s_axi_rresp    = q.rresp;
	assign s_axi_rvalid   = q.rvalid;
	assign cmd_done       = q.done;
	assign cmd_good       = q.good;
	assign cmd_hit        = q.hit;
	assign rd_blk_lba     = q.rlba;
	assign med_write      = q.mwr;
	assign med_lba        = q.mlba;
	assign med_count      = q.mcnt;
	assign deferred_error = q.defer;

	// Next state
	always_comb begin
		logic          clr_def;
		logic          set_def;
		logic [SW-1:0] idx;
		logic [7:0]    ra;
		clr_def = 1'b0;
		set_def = 1'b0;
		idx     = '0;
		ra      = {s_axi_araddr[7:2], 2'b00};
		n       = q;
		n.done  = 1'b0;
		n.defer = 1'b0;

		// Write once both halves held
		if (q.aw_got && q.w_got && !q.bvalid) begin
			n.bvalid = 1'b1;
			n.aw_got = 1'b0;
			n.w_got  = 1'b0;
			n.bresp  = `SDC_RESP_OKAY;
			if (q.awaddr == `SDC_OFS_CTRL) begin
				if (q.wstrb[0]) begin
					n.ctrl = q.wdata[3:0];  // see R19 R23
				end
			end else if (q.awaddr == `SDC_OFS_SEGSIZE) begin
				// Size never changes; param_check_a mode reports it
				if (q.ctrl[`SDC_CTRL_PCHK]) begin
					n.bresp = `SDC_RESP_SLVERR;  // see R8 R9
				end
			end else if (q.awaddr == `SDC_OFS_PFLIM) begin
				n.bresp = `SDC_RESP_OKAY;  // Accepted and dropped, see R20
			end else if (q.awaddr == `SDC_OFS_RATIO) begin
				if (q.wstrb[0]) begin
					n.ratio = q.wdata[7:0];
				end
			end else if (q.awaddr == `SDC_OFS_STATUS) begin
				clr_def = q.wstrb[0] && q.wdata[`SDC_STAT_DEF];
			end else if (q.awaddr == `SDC_OFS_CHITS || q.awaddr == `SDC_OFS_PHITS
				|| q.awaddr == `SDC_OFS_MISSES) begin
				n.bresp = `SDC_RESP_OKAY;  // Counters are read-only
			end else begin
				n.bresp = `SDC_RESP_DECERR;
			end
		end
		if (q.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (s_axi_awvalid && s_axi_awready) begin
			n.aw_got = 1'b1;
			n.awaddr = {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end

		// Read decode
		if (q.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			n.rvalid = 1'b1;
			n.rresp  = `SDC_RESP_OKAY;
			n.rdata  = '0;
			if (ra == `SDC_OFS_CTRL) begin
				n.rdata[3:0] = q.ctrl;
			end else if (ra == `SDC_OFS_SEGSIZE) begin
				n.rdata = `SDC_SEGSIZE_VAL;  // see R8
			end else if (ra == `SDC_OFS_PFLIM) begin
				n.rdata = '0;  // see R20
			end else if (ra == `SDC_OFS_RATIO) begin
				n.rdata[7:0] = q.ratio;
			end else if (ra == `SDC_OFS_STATUS) begin
				n.rdata[`SDC_STAT_DEF]  = q.def_st;
				n.rdata[`SDC_STAT_PFON] = pf_on;
				n.rdata[`SDC_STAT_BUSY] = (q.fsm != SDC_IDLE);
			end else if (ra == `SDC_OFS_CHITS) begin
				n.rdata[15:0] = q.n_chit;
			end else if (ra == `SDC_OFS_PHITS) begin
				n.rdata[15:0] = q.n_phit;
			end else if (ra == `SDC_OFS_MISSES) begin
				n.rdata[15:0] = q.n_miss;
			end else begin
				n.rresp = `SDC_RESP_DECERR;
			end
		end

		// Controller
		case (q.fsm)
			SDC_IDLE: begin
				if (cmd_valid) begin
					n.op      = cmd_op;
					n.lba     = cmd_lba;
					n.rlba    = cmd_lba;
					n.count   = cmd_count;
					n.sent    = '0;
					n.avail   = '0;
					n.rcvd    = '0;
					n.commit  = '0;
					n.started = 1'b0;
					n.mdone   = 1'b0;
					n.good    = 1'b1;
					n.hit     = SDC_MISS;
					n.fsm     = SDC_LOOKUP;
				end else if (|dirty_v) begin
					// Idle time drains cached writes
					n.cur = first_idx(dirty_v);
					n.dfl = 1'b1;
					n.ret = SDC_IDLE;
					n.fsm = SDC_FL_LOAD;
				end
			end
			SDC_LOOKUP: begin
				case (q.op)
					SDC_OP_READ: begin
						// Sequential reads train the predictor up
						if (q.lba == q.last_end) begin
							if (q.pred != 2'h3) n.pred = q.pred + 2'h1;  // see R21
						end else begin
							if (q.pred != 2'h0) n.pred = q.pred - 2'h1;  // see R21
						end
						n.last_end = req_end;
						// Read cache off: only prefetched data serves
						if (|(hit_v & (q.ctrl[`SDC_CTRL_RCO] ? pf_v : '1))) begin  // see R3 R4 R17
							idx   = first_idx(hit_v & (q.ctrl[`SDC_CTRL_RCO] ? pf_v : '1));
							n.cur = idx;
							n.hit = pf_v[idx] ? SDC_PF_HIT : SDC_CACHE_HIT;  // see R18
							if (pf_v[idx]) begin
								n.seg[idx].dem = 16'(req_end - q.seg[idx].start);
							end
							n.avail = q.count;  // see R5
							n.mdone = 1'b1;
							n.fsm   = SDC_RD_XFER;
						end else begin
							n.fsm = SDC_ALLOC;
						end
					end
					SDC_OP_WRITE: begin
						// Commit stale dirty data before dropping it
						if (|(ovl_v & dirty_v)) begin
							n.cur = first_idx(ovl_v & dirty_v);
							n.dfl = 1'b1;
							n.ret = SDC_LOOKUP;
							n.fsm = SDC_FL_LOAD;
						end else begin
							for (int k = 0; k < NSEG; k++) begin
								if (ovl_v[k]) n.seg[k].valid = 1'b0;  // see R12
							end
							if (q.count <= SEG_B && (q.ctrl[`SDC_CTRL_WCO] || !q.ctrl[`SDC_CTRL_RCO])) begin
								n.fsm = SDC_ALLOC;  // see R10
							end else begin
								n.mlba  = q.lba;
								n.mcnt  = q.count;
								n.mwr   = 1'b1;
								n.wthru = 1'b1;
								n.fsm   = SDC_WR_REQ;
							end
						end
					end
					SDC_OP_SYNC: begin
						if (|dirty_v) begin
							n.cur = first_idx(dirty_v);
							n.dfl = 1'b1;
							n.ret = SDC_LOOKUP;
							n.fsm = SDC_FL_LOAD;
						end else begin
							n.fsm = SDC_DONE;  // see R16
						end
					end
					default: begin
						n.good = 1'b0;
						n.fsm  = SDC_DONE;
					end
				endcase
			end
			SDC_ALLOC: begin
				// Shared pool, read cache flag ignored
				if (!(|free_v) && q.seg[q.rr].dirty) begin
					n.cur = q.rr;
					n.dfl = 1'b1;
					n.ret = SDC_ALLOC;
					n.fsm = SDC_FL_LOAD;  // see R13
				end else begin
					idx   = (|free_v) ? first_idx(free_v) : q.rr;  // see R7 R11
					n.cur = idx;
					n.rr  = (q.rr == SW'(NSEG - 1)) ? '0 : q.rr + SW'(1);
					n.seg[idx].valid = 1'b0;
					n.mlba  = q.lba;
					n.mwr   = 1'b0;
					n.wthru = 1'b0;
					// Prefetch tops the segment up past the request
					n.mcnt  = (pf_on && q.count < SEG_B) ? SEG_B : q.count;  // see R17 R21
					n.fsm   = (q.op == SDC_OP_READ) ? SDC_RD_REQ : SDC_WR_IN;
				end
			end
			SDC_RD_REQ: begin
				if (med_ready) n.fsm = SDC_RD_XFER;  // see R6
			end
			SDC_RD_XFER: begin
				if (med_blk && !q.mdone) n.avail = q.avail + 16'h0001;
				if (med_done && !q.mdone) begin
					n.mdone = 1'b1;
					if (med_err) n.good = 1'b0;
				end
				if (rd_blk_valid && rd_blk_ready) begin
					n.sent    = q.sent + 16'h0001;
					n.rlba    = q.rlba + ext(16'h0001);
					n.started = 1'b1;
				end
				if (q.mdone && (!q.good || q.sent == q.count)) begin
					if (q.hit == SDC_MISS) begin
						// Lapped oversized reads are not kept
						n.seg[q.cur].valid = q.good && q.count <= SEG_B;  // see R6 R7
						n.seg[q.cur].dirty = 1'b0;
						n.seg[q.cur].start = q.lba;
						n.seg[q.cur].dem   = q.count;
						n.seg[q.cur].total = q.avail;
					end
					n.fsm = SDC_DONE;
				end
			end
			SDC_WR_REQ: begin
				if (med_ready) n.fsm = SDC_WR_IN;
			end
			SDC_WR_IN: begin
				if (wr_blk_valid && wr_blk_ready) n.rcvd = q.rcvd + 16'h0001;
				if (q.wthru) begin
					if (med_blk) n.commit = q.commit + 16'h0001;
					if (med_done) begin
						n.good = !med_err;
						n.fsm  = SDC_DONE;
					end
				end else if (q.rcvd == q.count) begin
					n.seg[q.cur].valid = 1'b1;
					n.seg[q.cur].dirty = 1'b1;
					n.seg[q.cur].start = q.lba;
					n.seg[q.cur].dem   = q.count;
					n.seg[q.cur].total = q.count;
					if (q.ctrl[`SDC_CTRL_WCO]) begin
						n.fsm = SDC_DONE;  // see R14
					end else begin
						n.dfl = 1'b0;
						n.ret = SDC_DONE;
						n.fsm = SDC_FL_LOAD;
					end
				end
			end
			SDC_FL_LOAD: begin
				n.mlba = q.seg[q.cur].start;
				n.mcnt = q.seg[q.cur].total;
				n.mwr  = 1'b1;
				n.fsm  = SDC_FL_REQ;
			end
			SDC_FL_REQ: begin
				if (med_ready) n.fsm = SDC_FL_WAIT;
			end
			SDC_FL_WAIT: begin
				if (med_done) begin
					n.seg[q.cur].dirty = 1'b0;
					if (med_err) begin
						n.seg[q.cur].valid = 1'b0;
						if (q.dfl) begin
							set_def = 1'b1;  // see R15
							n.defer = 1'b1;
						end
						if (!q.dfl || (q.op == SDC_OP_SYNC && q.ret != SDC_IDLE)) n.good = 1'b0;
					end
					n.fsm = q.ret;
				end
			end
			SDC_DONE: begin
				n.done = 1'b1;
				if (q.op == SDC_OP_READ && q.good) begin
					if (q.hit == SDC_CACHE_HIT) n.n_chit = q.n_chit + 16'h0001;
					else if (q.hit == SDC_PF_HIT) n.n_phit = q.n_phit + 16'h0001;  // see R18
					else n.n_miss = q.n_miss + 16'h0001;
				end
				n.fsm = SDC_IDLE;
			end
			default: begin
				n.fsm = SDC_IDLE;
			end
		endcase

		// New failure beats same-cycle clear
		n.def_st = (q.def_st && !clr_def) || set_def;
	end

	// State register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q       <= '0;
			q.fsm   <= SDC_IDLE;
			q.ret   <= SDC_IDLE;
			q.pred  <= `SDC_PRED_RST;
			q.ctrl  <= `SDC_CTRL_RST;
			q.ratio <= `SDC_RATIO_RST;
		end else begin
			q <= n;
		end
	end

endmodule

// File: src/sdc_consts.svh
`ifndef SDC_CONSTS_SVH
`define SDC_CONSTS_SVH

// Buffer geometry
`define SDC_BUF_MBYTES    16
`define SDC_CACHE_KBYTES  13000
`define SDC_BLOCK_BYTES   512
`define SDC_CACHE_BLOCKS  (`SDC_CACHE_KBYTES * 1024 / `SDC_BLOCK_BYTES)
`define SDC_NSEG          4

// Register byte offsets
`define SDC_OFS_CTRL      8'h00
`define SDC_OFS_SEGSIZE   8'h04
`define SDC_OFS_PFLIM     8'h08
`define SDC_OFS_RATIO     8'h0C
`define SDC_OFS_STATUS    8'h10
`define SDC_OFS_CHITS     8'h14
`define SDC_OFS_PHITS     8'h18
`define SDC_OFS_MISSES    8'h1C

// Control field positions
`define SDC_CTRL_RCO      0
`define SDC_CTRL_WCO      1
`define SDC_CTRL_PFO      2
`define SDC_CTRL_PCHK     3

// Status field positions
`define SDC_STAT_DEF      0
`define SDC_STAT_PFON     1
`define SDC_STAT_BUSY     2

// Reset and fixed values
`define SDC_CTRL_RST      4'h0
`define SDC_RATIO_RST     8'h80
`define SDC_PRED_RST      2'h2
`define SDC_SEGSIZE_VAL   32'h0000_FFFF

// Bus responses
`define SDC_RESP_OKAY     2'h0
`define SDC_RESP_SLVERR   2'h2
`define SDC_RESP_DECERR   2'h3

`endif

// File: src/sdc_pkg.sv
package sdc_pkg;

	// Controller states
	typedef enum logic [3:0] {
		SDC_IDLE      = 4'h0,
		SDC_LOOKUP    = 4'h1,
		SDC_ALLOC     = 4'h2,
		SDC_RD_REQ    = 4'h3,
		SDC_RD_XFER   = 4'h4,
		SDC_WR_REQ    = 4'h5,
		SDC_WR_IN     = 4'h6,
		SDC_FL_LOAD   = 4'h7,
		SDC_FL_REQ    = 4'h8,
		SDC_FL_WAIT   = 4'h9,
		SDC_DONE      = 4'hA
	} sdc_fsm_type;

	// Host command codes
	typedef enum logic [1:0] {
		SDC_OP_READ   = 2'h0,
		SDC_OP_WRITE  = 2'h1,
		SDC_OP_SYNC   = 2'h2
	} sdc_op_type;

	// Read outcome classes
	typedef enum logic [1:0] {
		SDC_MISS      = 2'h0,
		SDC_CACHE_HIT = 2'h1,
		SDC_PF_HIT    = 2'h2
	} sdc_hit_type;

endpackage

// File: test/sdc_buffer_cache_props.sv
`timescale 1ns/1ps
module sdc_buffer_cache_props
	import sdc_pkg::*;
#(parameter int LBA_W = 32) (
	input wire              clock,
	input wire              rst_n,
	input wire [7:0]        s_axi_araddr,
	input wire              s_axi_arvalid,
	input wire              s_axi_arready,
	input wire [31:0]       s_axi_rdata,
	input wire              s_axi_rvalid,
	input wire              cmd_valid,
	input wire              cmd_ready,
	input wire sdc_op_type  cmd_op,
	input wire              cmd_done,
	input wire sdc_hit_type cmd_hit,
	input wire              rd_blk_valid,
	input wire              rd_blk_ready,
	input wire [LBA_W-1:0]  rd_blk_lba,
	input wire              med_valid,
	input wire              med_ready,
	input wire              med_write,
	input wire [LBA_W-1:0]  med_lba,
	input wire [15:0]       med_count,
	input wire              med_done,
	input wire              med_err,
	input wire              deferred_error
);
	logic cur_rd, cur_sync, med_used, med_busy, err_seen;	// Command and medium history
	// Command in flight; failed commit kept until reported
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) {cur_rd, cur_sync, med_used, med_busy, err_seen} <= '0;
		else begin
			if (cmd_valid && cmd_ready) begin
				cur_rd <= cmd_op == SDC_OP_READ;
				cur_sync <= cmd_op == SDC_OP_SYNC;
				med_used <= 1'h0;
			end else if (med_valid && med_ready) med_used <= 1'h1;
			if (med_valid && med_ready) med_busy <= 1'h1;
			else if (med_done) med_busy <= 1'h0;
			if (med_done && med_err) err_seen <= 1'h1;
			else if (deferred_error) err_seen <= 1'h0;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_ar(a);
		s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == a;
	endsequence
	a_segsize_read: assert property (s_ar(6'h01) |=> s_axi_rvalid && s_axi_rdata == 32'h0000_FFFF)
		else $error("bad segment size");
	a_pflim_read: assert property (s_ar(6'h02) |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
		else $error("limits not ignored");
	a_med_hold: assert property (med_valid && !med_ready |=> med_valid && $stable({med_lba, med_count, med_write}))
		else $error("medium request changed");
	a_rd_hold: assert property (rd_blk_valid && !rd_blk_ready |=> rd_blk_valid && $stable(rd_blk_lba))
		else $error("block offer changed");
	a_def_cause: assert property (deferred_error |-> err_seen)
		else $error("deferred error uncaused");
	a_def_pulse: assert property (deferred_error |=> !deferred_error)
		else $error("deferred error too long");
	a_hit_nomed: assert property (cmd_done && cur_rd && cmd_hit == SDC_CACHE_HIT |-> !med_used)
		else $error("hit used medium");
	a_sync_flushed: assert property (cmd_done && cur_sync |-> !med_busy && !med_valid)
		else $error("sync left medium busy");
endmodule
bind sdc_buffer_cache sdc_buffer_cache_props #(.LBA_W(LBA_W)) i_props (.*);

// File: test/sdc_buffer_cache_tb_top.sv
`timescale 1ns/1ps
module sdc_buffer_cache_tb_top;
	import sdc_pkg::*;
	logic clock, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic cmd_valid, rd_blk_ready, wr_blk_valid, fail, slow;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [3:0] s_axi_wstrb;
	logic [31:0] s_axi_wdata, cmd_lba;
	logic [15:0] cmd_count;
	sdc_op_type cmd_op;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmd_ready, cmd_done;
	wire cmd_good, rd_blk_valid, wr_blk_ready, med_valid, med_ready, med_write, med_blk, med_done;
	wire med_err, deferred_error;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata, rd_blk_lba, med_lba, wr_blks;
	wire [15:0] med_count;
	wire sdc_hit_type cmd_hit;
	int n_fail, comparisons, cyc, nblk;	// Tallies
	// Small segments
	sdc_buffer_cache #(.SEG_BLOCKS(8)) i_dut (.*);
	sdc_medium_model i_med (.clock, .rst_n, .med_valid, .med_ready, .med_write, .med_count, .med_blk,
		.med_done, .med_err, .fail, .slow, .wr_blks);
	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end
	// Hang guard, block count
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (rd_blk_valid && rd_blk_ready) nblk <= nblk + 1;
		if (cyc == 40000) begin
			n_fail++;
			final_report;
		end
	end
	task automatic chk(input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		chk(32'(s_axi_bresp), 32'(r));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		chk(s_axi_rdata & m, e);
	endtask
	// One command: status, class, block count
	task automatic cmd(input sdc_op_type op, input logic [31:0] l, input logic [15:0] c, input logic g, input int h);
		int n0;
		cmd_op <= op;
		cmd_lba <= l;
		cmd_count <= c;
		cmd_valid <= 1'h1;
		do @(posedge clock); while (!cmd_ready);
		cmd_valid <= 1'h0;
		n0 = nblk;
		do @(posedge clock); while (!cmd_done);
		chk(32'(cmd_good), 32'(g));
		if (op == SDC_OP_READ) chk(nblk - n0, 32'(c));
		if (h >= 0) chk(32'(cmd_hit), h);
	endtask
	task t_regs;
		rd(8'h0C, 32'h0000_00FF, 32'h0000_0080);
		wr(8'h04, 32'h0000_0100, 2'h0);
		rd(8'h04, 32'hFFFF_FFFF, 32'h0000_FFFF);
		wr(8'h08, 32'h0000_1234, 2'h0);
		rd(8'h08, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(8'h00, 32'h0000_0008, 2'h0);
		wr(8'h04, 32'h0000_0100, 2'h2);
		wr(8'h20, 32'h0000_0000, 2'h3);
	endtask
	task t_reads;
		slow <= 1'h1;
		cmd(SDC_OP_READ, 32'h0, 16'h2, 1'h1, 0);
		cmd(SDC_OP_READ, 32'h2, 16'h2, 1'h1, -1);
		cmd(SDC_OP_READ, 32'h4, 16'h2, 1'h1, 2);
		cmd(SDC_OP_READ, 32'h4, 16'h2, 1'h1, 1);
		slow <= 1'h0;
	endtask
	task t_wcache;
		logic [31:0] w0;
		wr(8'h00, 32'h0000_0002, 2'h0);
		w0 = wr_blks;
		cmd(SDC_OP_WRITE, 32'h4, 16'h2, 1'h1, -1);
		chk(wr_blks, w0);
		cmd(SDC_OP_SYNC, 32'h0, 16'h1, 1'h1, -1);
		chk(wr_blks, w0 + 32'h2);
		cmd(SDC_OP_READ, 32'h4, 16'h2, 1'h1, 1);
		cmd(SDC_OP_READ, 32'h2, 16'h1, 1'h1, 0);
	endtask
	task t_defer;
		fail <= 1'h1;
		cmd(SDC_OP_WRITE, 32'h28, 16'h1, 1'h1, -1);
		do @(posedge clock); while (!deferred_error);
		fail <= 1'h0;
		rd(8'h10, 32'h0000_0001, 32'h0000_0001);
		wr(8'h10, 32'h0000_0001, 2'h0);
		rd(8'h10, 32'h0000_0001, 32'h0000_0000);
	endtask
	task t_nocache;
		wr(8'h00, 32'h0000_0005, 2'h0);
		cmd(SDC_OP_READ, 32'h4, 16'h2, 1'h1, 0);
	endtask
	// Scenarios
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, cmd_valid, fail, slow} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, cmd_lba, cmd_count} = '0;
		{rd_blk_ready, wr_blk_valid, s_axi_bready, s_axi_rready, s_axi_wstrb} = 8'hFF;
		cmd_op = SDC_OP_READ;
		rst_n = 1'h0;
		repeat (12) @(posedge clock);
		rst_n <= 1'h1;
		@(posedge clock);
		t_regs;
		t_reads;
		t_wcache;
		t_defer;
		t_nocache;
		final_report;
	end
endmodule

// File: test/sdc_medium_model.sv
`timescale 1ns/1ps
module sdc_medium_model (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        med_valid,
	output logic             med_ready,
	input  wire logic        med_write,
	input  wire logic [15:0] med_count,
	output logic             med_blk,
	output logic             med_done,
	output logic             med_err,
	input  wire logic        fail,
	input  wire logic        slow,
	output logic [31:0]      wr_blks
);
	logic        busy;	// Request in progress
	logic        wr;	// Request writes
	logic [15:0] left;	// Blocks still to move
	logic [1:0]  gap;	// Idle cycles before next block
	// One request at a time; slow mode spaces blocks out
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{med_ready, med_blk, med_done, med_err, busy, wr, left, gap} <= '0;
			wr_blks <= '0;
		end else begin
			med_ready <= !busy && med_valid && !med_ready;
			med_blk <= 1'h0;
			med_done <= 1'h0;
			med_err <= 1'h0;
			if (med_valid && med_ready) begin
				busy <= 1'h1;
				wr <= med_write;
				left <= med_count;
			end else if (busy && gap != 2'h0) gap <= gap - 2'h1;
			else if (busy && left != 16'h0) begin
				med_blk <= 1'h1;
				left <= left - 16'h1;
				gap <= slow ? 2'h3 : 2'h0;
				if (wr) wr_blks <= wr_blks + 32'h1;
			end else if (busy) begin
				med_done <= 1'h1;
				med_err <= fail;	// Injected commit failure
				busy <= 1'h0;
			end
		end
	end
endmodule
